// *** src/rcwi_map.svh ***
`ifndef RCWI_MAP_SVH
`define RCWI_MAP_SVH

// Database indices of the command sources.
`define RCWI_IDX_WORD    16'h01f9
`define RCWI_IDX_UPPER   16'h01fa
// Single-bit command indices, lowest and highest.
`define RCWI_IDX_BIT_LO  16'h021d
`define RCWI_IDX_BIT_HI  16'h022c
// Configuration indices: format, rate, identifier range, device number.
`define RCWI_IDX_FORMAT  16'h0c58
`define RCWI_IDX_RATE    16'h26c1
`define RCWI_IDX_CANID   16'h26c0
`define RCWI_IDX_DEVNUM  16'h06a6
// First result index of flags 1-8 and of flags 9-16.
`define RCWI_IDX_FLAG_A  16'h29cc
`define RCWI_IDX_FLAG_B  16'h2d59
// Number of flags in each result group.
`define RCWI_FLAG_GROUP  16'h0008

// Message interval in hundredths of a second: 0.10 s to 0.30 s.
`define RCWI_RATE_MIN    5'h0a
`define RCWI_RATE_MAX    5'h1e
`define RCWI_RATE_DEF    5'h0a
// Leading identifier digit range and default.
`define RCWI_RANGE_MIN   3'h2
`define RCWI_RANGE_MAX   3'h5
`define RCWI_RANGE_DEF   3'h5
// Device number after reset.
`define RCWI_DEVNUM_DEF  8'h01
// Clock period and interval tick, both in ns (10 ns and 10 ms).
`define RCWI_CLK_NS      32'h0000_000a
`define RCWI_TICK_NS     32'h0098_9680

`endif

// *** src/rcwi_pkg.sv ***
`default_nettype none
// Types shared by the remote command intake files.
package rcwi_pkg;

    // Remote command format selector.
    typedef enum logic [0:0] {
        RCWI_FMT_16 = 1'h0,
        RCWI_FMT_8  = 1'h1
    } rcwi_fmt_e;

    // Whole state of the top module.
    typedef struct packed {
        logic [15:0] w505;     // Stored command word.
        logic [7:0]  w506;     // Stored upper command byte.
        rcwi_fmt_e   fmt;      // Selected format.
        logic [4:0]  rate;     // Interval in hundredths of a second.
        logic [2:0]  range;    // Leading identifier digit.
        logic [7:0]  devnum;   // Device number.
        logic [15:0] cmd;      // Command variables 16 down to 1.
        logic [15:0] rdata;    // Read answer.
        logic        rvalid;   // Read answer strobe.
        logic        tx;       // Message send strobe.
        logic [10:0] can_id;   // Load-share identifier.
    } rcwi_state_s;

    // Whole state of the interval timer.
    typedef struct packed {
        logic [19:0] tick_cnt; // Clock cycles within one 10 ms tick.
        logic [4:0]  ticks;    // Ticks since last message.
        logic        fire;     // One-cycle send pulse.
    } rcwi_timer_s;

endpackage
`default_nettype wire

// *** src/rcwi_period_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rcwi_map.svh"
// Fires one pulse each time the configured number of 10 ms ticks passes.
module rcwi_period_timer #(
    parameter int unsigned TICK_CYCLES = `RCWI_TICK_NS / `RCWI_CLK_NS
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Interval in ticks.
    input  wire logic [4:0] period,
    // Send pulse.
    output logic            fire
);

    rcwi_pkg::rcwi_timer_s s;       // Current state.
    rcwi_pkg::rcwi_timer_s next_s;  // Next state.

    // Tick divider and interval counter; a shortened period ends at the end of the current tick.
    always_comb begin
        next_s = s;
        next_s.fire = 1'b0;
        if (s.tick_cnt == 20'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = 20'h0_0000;
            if (5'(s.ticks + 5'h01) >= period) begin
                next_s.ticks = 5'h00;
                next_s.fire  = 1'b1;
            end else begin
                next_s.ticks = 5'(s.ticks + 5'h01);
            end
        end else begin
            next_s.tick_cnt = 20'(s.tick_cnt + 20'h0_0001);
        end
    end

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign fire = s.fire;

endmodule // rcwi_period_timer
`default_nettype wire

// *** src/rcwi_flag_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rcwi_map.svh"
// Decodes a read index onto the result of one of sixteen internal flags.
module rcwi_flag_bank (
    // Read index.
    input  wire logic [15:0] index,
    // Flag results 16 down to 1.
    input  wire logic [15:0] flags,
    // Decode result.
    output logic             hit,
    output logic             value
);

    logic [15:0] off_a;  // Offset into the first group.
    logic [15:0] off_b;  // Offset into the second group.

    // Each flag result sits at its own index in one of two groups.
    always_comb begin
        off_a = 16'(index - `RCWI_IDX_FLAG_A);
        off_b = 16'(index - `RCWI_IDX_FLAG_B);
        hit   = 1'b0;
        value = 1'b0;
        if (off_a < `RCWI_FLAG_GROUP) begin
            hit   = 1'b1;
            value = flags[off_a[2:0]];
        end else if (off_b < `RCWI_FLAG_GROUP) begin
            hit   = 1'b1;
            value = flags[{1'b1, off_b[2:0]}];
        end
    end

endmodule // rcwi_flag_bank
`default_nettype wire

// *** src/rcwi_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rcwi_map.svh"
// Remote command intake: turns database writes and received process
// data objects into sixteen command variables, serves reads of the
// stored words and flag results, and paces the load-share message.
module rcwi_top #(
    // Clock cycles in one 10 ms tick; shorten for simulation.
    parameter int unsigned TICK_CYCLES = `RCWI_TICK_NS / `RCWI_CLK_NS
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Parameter database access.
    input  wire logic        db_wr,
    input  wire logic        db_rd,
    input  wire logic [15:0] db_index,
    input  wire logic [15:0] db_wdata,
    output logic [15:0]      db_rdata,
    output logic             db_rvalid,
    // Received process data objects.
    input  wire logic        pdo_valid,
    input  wire logic        pdo_sel,
    input  wire logic [15:0] pdo_data,
    // Internal flag results 16 down to 1.
    input  wire logic [15:0] flag_result,
    // Command variables 16 down to 1.
    output logic [15:0]      cmd_var,
    // Load-share message pacing and identifier.
    output logic             load_share_tx,
    output logic [10:0]      load_share_can_id
);

    rcwi_pkg::rcwi_state_s s;       // Current state.
    rcwi_pkg::rcwi_state_s next_s;  // Next state.
    logic                  fire;    // Interval timer pulse.
    logic                  f_hit;   // Read index names a flag result.
    logic                  f_val;   // Addressed flag result.
    logic [3:0]            pos;     // Bit addressed by a single write.

    // Maps a single-bit index onto a bit position: 556 is bit 0.
    function automatic logic [3:0] bit_pos(input logic [15:0] idx);
        logic [15:0] d;
        d = 16'(`RCWI_IDX_BIT_HI - idx);
        return d[3:0];
    endfunction

    // True when an index falls within the single-bit write range.
    function automatic logic is_bit(input logic [15:0] idx);
        return (idx >= `RCWI_IDX_BIT_LO) && (idx <= `RCWI_IDX_BIT_HI);
    endfunction

    // Interval timer paces the fast message.
    rcwi_period_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .period  (s.rate),
        .fire    (fire)
    );

    // Flag result decoder for reads.
    rcwi_flag_bank u_flags (
        .index (db_index),
        .flags (flag_result),
        .hit   (f_hit),
        .value (f_val)
    );

    // Next state: writes first, then objects, then derived outputs.
    always_comb begin
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.tx     = fire;
        pos           = bit_pos(db_index);
        // Database writes.
        if (db_wr) begin
            if (db_index == `RCWI_IDX_WORD) begin
                next_s.w505 = db_wdata;
            end else if (db_index == `RCWI_IDX_UPPER) begin
                next_s.w506 = db_wdata[7:0];
            end else if (is_bit(db_index)) begin
                // Single binary order lands in whichever source feeds it.
                if (s.fmt == rcwi_pkg::RCWI_FMT_8 && pos[3]) begin
                    next_s.w506[pos[2:0]] = db_wdata[0];
                end else begin
                    next_s.w505[pos] = db_wdata[0];
                end
            end else if (db_index == `RCWI_IDX_FORMAT) begin
                next_s.fmt = rcwi_pkg::rcwi_fmt_e'(db_wdata[0]);
            end else if (db_index == `RCWI_IDX_RATE) begin
                // Out-of-range intervals are ignored.
                if (db_wdata >= 16'(`RCWI_RATE_MIN) &&
                    db_wdata <= 16'(`RCWI_RATE_MAX)) begin
                    next_s.rate = db_wdata[4:0];
                end
            end else if (db_index == `RCWI_IDX_CANID) begin
                // Only digits 2 to 5 are accepted.
                if (db_wdata >= 16'(`RCWI_RANGE_MIN) &&
                    db_wdata <= 16'(`RCWI_RANGE_MAX)) begin
                    next_s.range = db_wdata[2:0];
                end
            end else if (db_index == `RCWI_IDX_DEVNUM) begin
                next_s.devnum = db_wdata[7:0];
            end
        end
        // Received objects override a database write in the same cycle.
        if (pdo_valid) begin
            if (s.fmt == rcwi_pkg::RCWI_FMT_16) begin
                // Only the first object carries the word in this format.
                if (!pdo_sel) begin
                    next_s.w505 = pdo_data;
                end
            end else if (pdo_sel) begin
                next_s.w506 = pdo_data[7:0];
            end else begin
                next_s.w505[7:0] = pdo_data[7:0];
            end
        end
        // Command variables follow the stored sources only.
        if (s.fmt == rcwi_pkg::RCWI_FMT_16) begin
            next_s.cmd = s.w505;
        end else begin
            next_s.cmd = {s.w506, s.w505[7:0]};
        end
        // Identifier: leading digit over device number.
        next_s.can_id = {s.range, s.devnum};
        // Reads answer one cycle later; unknown indices read zero.
        if (db_rd) begin
            next_s.rvalid = 1'b1;
            if (db_index == `RCWI_IDX_WORD) begin
                next_s.rdata = s.w505;
            end else if (db_index == `RCWI_IDX_UPPER) begin
                next_s.rdata = {8'h00, s.w506};
            end else if (is_bit(db_index)) begin
                next_s.rdata = {15'h0000, s.cmd[pos]};
            end else if (db_index == `RCWI_IDX_FORMAT) begin
                next_s.rdata = {15'h0000, s.fmt};
            end else if (db_index == `RCWI_IDX_RATE) begin
                next_s.rdata = {11'h000, s.rate};
            end else if (db_index == `RCWI_IDX_CANID) begin
                next_s.rdata = {13'h0000, s.range};
            end else if (db_index == `RCWI_IDX_DEVNUM) begin
                next_s.rdata = {8'h00, s.devnum};
            end else if (f_hit) begin
                next_s.rdata = {15'h0000, f_val};
            end else begin
                next_s.rdata = 16'h0000;
            end
        end
    end

    // State register with documented defaults.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s        <= '0;
            s.fmt    <= rcwi_pkg::RCWI_FMT_16;
            s.rate   <= `RCWI_RATE_DEF;
            s.range  <= `RCWI_RANGE_DEF;
            s.devnum <= `RCWI_DEVNUM_DEF;
            s.can_id <= {`RCWI_RANGE_DEF, `RCWI_DEVNUM_DEF};
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register.
    assign db_rdata          = s.rdata;
    assign db_rvalid         = s.rvalid;
    assign cmd_var           = s.cmd;
    assign load_share_tx     = s.tx;
    assign load_share_can_id = s.can_id;

    // Checks of the documented behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Interval always inside 0.10 s to 0.30 s.
    property p_rate_range;
        s.rate >= `RCWI_RATE_MIN && s.rate <= `RCWI_RATE_MAX;
    endproperty
    a_rate_range: assert property (p_rate_range)
        else $error("Message interval left its range.");

    // Send strobe is a single-cycle pulse.
    property p_tx_pulse;
        load_share_tx |=> !load_share_tx;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("Send strobe lasted more than one cycle.");

    // Leading identifier digit stays within 2 to 5.
    property p_can_hi;
        load_share_can_id[10:8] >= `RCWI_RANGE_MIN &&
        load_share_can_id[10:8] <= `RCWI_RANGE_MAX;
    endproperty
    a_can_hi: assert property (p_can_hi)
        else $error("Identifier range digit out of range.");

    // Identifier low byte follows the device number.
    property p_can_lo;
        ##1 load_share_can_id[7:0] == $past(s.devnum);
    endproperty
    a_can_lo: assert property (p_can_lo)
        else $error("Identifier low byte not the device number.");

    // Command variables move only two cycles after an interface access.
    property p_cmd_source;
        !$stable(cmd_var) |-> $past(db_wr || pdo_valid, 2);
    endproperty
    a_cmd_source: assert property (p_cmd_source)
        else $error("Command variables changed without an access.");

    // Word format: written word reaches all sixteen variables.
    property p_word16;
        db_wr && db_index == `RCWI_IDX_WORD && !pdo_valid &&
        s.fmt == rcwi_pkg::RCWI_FMT_16 && !$past(db_wr) |=>
        ##1 cmd_var == $past(db_wdata, 2);
    endproperty
    a_word16: assert property (p_word16)
        else $error("Word write did not reach the variables.");

    // Byte format: variables join the two low bytes.
    property p_byte8;
        s.fmt == rcwi_pkg::RCWI_FMT_8 |=>
        cmd_var == {$past(s.w506), $past(s.w505[7:0])};
    endproperty
    a_byte8: assert property (p_byte8)
        else $error("Byte format mapping wrong.");

    // Index 556 sets variable 1 in word format.
    property p_bit_write;
        db_wr && db_index == `RCWI_IDX_BIT_HI && !pdo_valid &&
        s.fmt == rcwi_pkg::RCWI_FMT_16 |=> s.w505[0] == $past(db_wdata[0]);
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("Single-bit write missed variable 1.");

    // Word format: first object replaces the whole word.
    property p_pdo16;
        pdo_valid && !pdo_sel && s.fmt == rcwi_pkg::RCWI_FMT_16 |=>
        s.w505 == $past(pdo_data);
    endproperty
    a_pdo16: assert property (p_pdo16)
        else $error("Object word not taken.");

    // Byte format: second object fills variables 9 to 16.
    property p_pdo8;
        pdo_valid && pdo_sel && s.fmt == rcwi_pkg::RCWI_FMT_8 |=>
        s.w506 == $past(pdo_data[7:0]);
    endproperty
    a_pdo8: assert property (p_pdo8)
        else $error("Second object byte not taken.");

    // Reading the flag 1 result returns that flag.
    property p_flag_read;
        db_rd && db_index == `RCWI_IDX_FLAG_A |=>
        db_rvalid && db_rdata == {15'h0000, $past(flag_result[0])};
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("Flag result read wrong.");

    // Every read is answered once, exactly one cycle after its request.
    property p_read_answer;
        db_rvalid == $past(db_rd);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("Read answer strobe out of step.");

    // Word format leaves both sources alone on a second object.
    property p_pdo16_refuse;
        pdo_valid && pdo_sel && s.fmt == rcwi_pkg::RCWI_FMT_16 && !db_wr |=>
        $stable(s.w505) && $stable(s.w506);
    endproperty
    a_pdo16_refuse: assert property (p_pdo16_refuse)
        else $error("Second object taken in word format.");

    // Interval writes outside 0.10 s to 0.30 s leave the interval alone.
    property p_rate_refuse;
        db_wr && db_index == `RCWI_IDX_RATE &&
        (db_wdata < 16'(`RCWI_RATE_MIN) ||
         db_wdata > 16'(`RCWI_RATE_MAX)) |=> $stable(s.rate);
    endproperty
    a_rate_refuse: assert property (p_rate_refuse)
        else $error("Out-of-range interval taken.");

    // Identifier digits outside 2 to 5 leave the digit alone.
    property p_range_refuse;
        db_wr && db_index == `RCWI_IDX_CANID &&
        (db_wdata < 16'(`RCWI_RANGE_MIN) ||
         db_wdata > 16'(`RCWI_RANGE_MAX)) |=> $stable(s.range);
    endproperty
    a_range_refuse: assert property (p_range_refuse)
        else $error("Out-of-range identifier digit taken.");

    // Any single-bit write reaches its own variable in either format.
    property p_bit_any;
        db_wr && is_bit(db_index) && !pdo_valid |=>
        ##1 cmd_var[$past(bit_pos(db_index), 2)] == $past(db_wdata[0], 2);
    endproperty
    a_bit_any: assert property (p_bit_any)
        else $error("Single-bit write missed its variable.");

    // Byte format: first object fills variables 1 to 8.
    property p_pdo8_low;
        pdo_valid && !pdo_sel && s.fmt == rcwi_pkg::RCWI_FMT_8 |=>
        s.w505[7:0] == $past(pdo_data[7:0]);
    endproperty
    a_pdo8_low: assert property (p_pdo8_low)
        else $error("First object byte not taken.");

    // Main scenarios.
    c_tx: cover property (load_share_tx);
    c_fmt8_pdo: cover property (pdo_valid && pdo_sel &&
                                s.fmt == rcwi_pkg::RCWI_FMT_8);
    c_bit_write: cover property (db_wr && is_bit(db_index));
    c_fmt16_pdo: cover property (pdo_valid && !pdo_sel &&
                                 s.fmt == rcwi_pkg::RCWI_FMT_16);
    c_rate_write: cover property (db_wr && db_index == `RCWI_IDX_RATE);

endmodule // rcwi_top
`default_nettype wire

// *** tb/rcwi_remote_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Remote controller on the far side: database writes and reads and
// received process data objects, one request per task call.
module rcwi_remote_model (
    // Clock.
    input  wire logic        ref_clk,
    // Database answer.
    input  wire logic [15:0] db_rdata,
    input  wire logic        db_rvalid,
    // Database request.
    output logic             db_wr,
    output logic             db_rd,
    output logic [15:0]      db_index,
    output logic [15:0]      db_wdata,
    // Process data objects.
    output logic             pdo_valid,
    output logic             pdo_sel,
    output logic [15:0]      pdo_data
);
    // Idle bus at time zero.
    initial begin
        db_wr = 1'b0;
        db_rd = 1'b0;
        db_index = 16'h0000;
        db_wdata = 16'h0000;
        pdo_valid = 1'b0;
        pdo_sel = 1'b0;
        pdo_data = 16'h0000;
    end

    // One write; released lines show the inverse of their last value.
    task automatic db_write(input logic [15:0] idx, input logic [15:0] dat);
        @(posedge ref_clk);
        db_wr <= 1'b1;
        db_index <= idx;
        db_wdata <= dat;
        @(posedge ref_clk);
        db_wr <= 1'b0;
        db_index <= ~idx;
        db_wdata <= ~dat;
    endtask

    // One read; the answer is taken when its strobe is seen, bounded.
    task automatic db_read(input logic [15:0] idx, output logic [15:0] dat);
        int n;
        @(posedge ref_clk);
        db_rd <= 1'b1;
        db_index <= idx;
        @(posedge ref_clk);
        db_rd <= 1'b0;
        db_index <= ~idx;
        #1;
        n = 0;
        while (db_rvalid !== 1'b1 && n < 3) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        dat = (db_rvalid === 1'b1) ? db_rdata : 16'hxxxx;
    endtask

    // One received object, whole word or one of two byte objects.
    task automatic pdo_send(input logic sel, input logic [15:0] dat);
        @(posedge ref_clk);
        pdo_valid <= 1'b1;
        pdo_sel <= sel;
        pdo_data <= dat;
        @(posedge ref_clk);
        pdo_valid <= 1'b0;
        pdo_sel <= ~sel;
        pdo_data <= ~dat;
    endtask
endmodule // rcwi_remote_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Compares two values and counts the outcome.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("FAIL t=%0t got %h exp %h", $time, got, exp); \
    end end
// Self-checking bench of the remote command intake.
module tb_top;
    localparam int unsigned TICK = 4; // Short tick keeps intervals small.
    logic        ref_clk;            // Bench clock.
    logic        rst;                // Reset, active high.
    logic [15:0] flag_result;        // Flag results driven by the bench.
    logic        db_wr;              // Database write strobe.
    logic        db_rd;              // Database read strobe.
    logic [15:0] db_index;           // Database index.
    logic [15:0] db_wdata;           // Database write data.
    logic [15:0] db_rdata;           // Database read answer.
    logic        db_rvalid;          // Read answer strobe.
    logic        pdo_valid;          // Object strobe.
    logic        pdo_sel;            // Object selector.
    logic [15:0] pdo_data;           // Object payload.
    logic [15:0] cmd_var;            // Command variables.
    logic        load_share_tx;      // Message send pulse.
    logic [10:0] load_share_can_id;  // Message identifier.
    int          miscompares = 0;    // Mismatches seen.
    int          n_checks = 0;       // Comparisons made.
    integer      seed = 31;          // Fixed seed.
    logic [15:0] w505;               // Expected stored word.
    logic [7:0]  w506;               // Expected stored upper byte.
    logic        fmt8;               // Expected format, 1 = byte format.
    logic [2:0]  dg;                 // Expected identifier digit.
    logic [7:0]  dn;                 // Expected device number.
    logic [15:0] d;                  // Scratch data.
    logic [15:0] rd;                 // Read answer.
    int          gap;                // Measured message interval.

    rcwi_top #(.TICK_CYCLES(TICK)) dut (
        .ref_clk(ref_clk), .rst(rst), .db_wr(db_wr), .db_rd(db_rd),
        .db_index(db_index), .db_wdata(db_wdata), .db_rdata(db_rdata),
        .db_rvalid(db_rvalid), .pdo_valid(pdo_valid), .pdo_sel(pdo_sel),
        .pdo_data(pdo_data), .flag_result(flag_result), .cmd_var(cmd_var),
        .load_share_tx(load_share_tx),
        .load_share_can_id(load_share_can_id)
    );

    rcwi_remote_model u_remote (
        .ref_clk(ref_clk), .db_rdata(db_rdata), .db_rvalid(db_rvalid),
        .db_wr(db_wr), .db_rd(db_rd), .db_index(db_index),
        .db_wdata(db_wdata), .pdo_valid(pdo_valid), .pdo_sel(pdo_sel),
        .pdo_data(pdo_data)
    );

    // 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Expected command variables from the stored sources.
    function automatic logic [15:0] exp_cmd();
        return fmt8 ? {w506, w505[7:0]} : w505;
    endfunction

    // Lets the two-edge command update land, then compares.
    task automatic settle_chk();
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(cmd_var, exp_cmd())
    endtask

    // Measures the cycles between two send pulses, bounded.
    task automatic tx_gap();
        int n;
        n = 0;
        while (load_share_tx !== 1'b1 && n < 500) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        #1;
        gap = 1;
        while (load_share_tx !== 1'b1 && gap < 500) begin
            @(posedge ref_clk);
            #1;
            gap++;
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #500000;
        miscompares++;
        $display("FAIL t=%0t watchdog expired", $time);
        close_out();
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        flag_result = 16'h0000;
        w505 = 16'h0000;
        w506 = 8'h00;
        fmt8 = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK(cmd_var, 16'h0000)
        `CHK(load_share_can_id, 11'h501)
        // Word writes in the default format, one corner value first.
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'h8001 : 16'($random(seed));
            u_remote.db_write(16'h01f9, d);
            w505 = d;
            settle_chk();
        end
        u_remote.db_read(16'h01f9, rd);
        `CHK(rd, w505)
        u_remote.db_read(16'h0007, rd);
        `CHK(rd, 16'h0000)
        // Single-bit writes, variable n at index 557 - n.
        for (int n = 1; n <= 16; n++) begin
            d = {15'h0000, 1'($random(seed))};
            u_remote.db_write(16'(557 - n), d);
            w505[n - 1] = d[0];
            settle_chk();
        end
        // Whole-word object; a second object is refused here.
        d = 16'($random(seed));
        u_remote.pdo_send(1'b0, d);
        w505 = d;
        settle_chk();
        u_remote.pdo_send(1'b1, ~d);
        settle_chk();
        // Byte format: low bytes of both sources.
        u_remote.db_write(16'h0c58, 16'h0001);
        fmt8 = 1'b1;
        d = 16'($random(seed));
        u_remote.db_write(16'h01f9, d);
        w505 = d;
        d = 16'($random(seed));
        u_remote.db_write(16'h01fa, d);
        w506 = d[7:0];
        settle_chk();
        u_remote.db_write(16'(557 - 9), {15'h0000, ~w506[0]});
        w506[0] = ~w506[0];
        settle_chk();
        d = 16'($random(seed));
        u_remote.pdo_send(1'b0, d);
        w505[7:0] = d[7:0];
        d = 16'($random(seed));
        u_remote.pdo_send(1'b1, d);
        w506 = d[7:0];
        settle_chk();
        // Identifier digit and device number, one digit out of range.
        dn = 8'($random(seed));
        dg = 3'h5;
        u_remote.db_write(16'h06a6, {8'h00, dn});
        for (int k = 2; k <= 6; k++) begin
            u_remote.db_write(16'h26c0, 16'(k));
            if (k <= 5) dg = 3'(k);
            settle_chk();
            `CHK(load_share_can_id, {dg, dn})
        end
        // Interval: default, longest, then an ignored value.
        tx_gap();
        `CHK(gap, 10 * TICK)
        u_remote.db_write(16'h26c1, 16'h001e);
        tx_gap();
        tx_gap();
        `CHK(gap, 30 * TICK)
        u_remote.db_write(16'h26c1, 16'h0009);
        tx_gap();
        tx_gap();
        `CHK(gap, 30 * TICK)
        // Flag results at their read indices.
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            flag_result <= 16'($random(seed));
            u_remote.db_read(16'(10700 + i), rd);
            `CHK(rd, {15'h0000, flag_result[i]})
            u_remote.db_read(16'(11609 + i), rd);
            `CHK(rd, {15'h0000, flag_result[8 + i]})
        end
        close_out();
    end
endmodule // tb_top
`default_nettype wire
